// ==== src/dma_sg_channel.v ====
// One scatter/gather DMA channel: registers, descriptor walker and byte-count engine.
//
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
`include "dma_sg_defs.vh"

// Summary of operation
// - Mode bit 17 routes interrupt PCI or local.
// - DAC load bit: descriptor or held upper.
// - End-link set: end-of-transfer ends current link.
// - End-link clear: end-of-transfer ends whole chain.
// - Valid mode gates descriptors on valid flag.
// - Valid, zero count, not last: skip.
// - Valid mode uses reordered descriptor layout.
// - Stop control clear: poll invalid descriptor.
// - Stop control set: halt on invalid descriptor.
// - Clearing start to pause sets done.
// - PCI side begins at PCI start address.
// - Local side begins at local start address.
// - Size low 23 bits hold byte count.
// - Size bit 31 valid; 30:23 read zero.
// - Pointer bit 0 selects descriptor space.
// - Pointer bit 1 marks chain end.
// - Pointer bit 2 interrupts at terminal count.
// - Pointer bit 3 sets transfer direction.
// - Scatter/gather loads addresses, count from memory.
// - Start begins only when channel enabled.
// - Done reads 1 when finished or aborted.
module dma_sg_channel (
    // Clock, reset and clock enable
    input  wire        clk_i,
    input  wire        rst_n_i,
    input  wire        ce_i,
    // Register port
    input  wire [3:0]  reg_addr_i,
    input  wire [31:0] reg_wdata_i,
    input  wire        reg_wr_i,
    input  wire        reg_rd_i,
    output reg  [31:0] reg_rdata_o,
    // Descriptor fetch port, one word per request
    output reg         desc_req_o,
    output reg         desc_in_pci_o,
    output reg  [31:0] desc_addr_o,
    input  wire        desc_ack_i,
    input  wire [31:0] desc_data_i,
    // Data mover port
    output reg         move_active_o,
    output reg         move_loc_to_pci_o,
    output reg  [31:0] move_pci_addr_o,
    output reg  [31:0] move_dac_o,
    output reg  [31:0] move_loc_addr_o,
    input  wire        move_beat_i,
    // Pins
    input  wire        end_of_transfer_input_n_i,
    output reg         pci_inta_n_o,
    output reg         local_interrupt_out_n_o
);

    // Registers.
    reg [31:0] mode_q;
    reg [31:0] pci_addr_q;
    reg [31:0] loc_addr_q;
    reg [31:0] size_q;
    reg [31:0] ptr_q;
    reg [31:0] dac_q;
    reg        enable_q;
    reg        start_q;
    reg        done_q;
    reg        int_q;
    reg [2:0]  state_q;
    reg [1:0]  wcnt_q;
    reg [31:0] desc_base_q;
    reg        desc_space_q;
    reg [31:0] w_q [0:3];
    reg [22:0] count_q;
    reg        halted_q;

    // End-of-transfer pin synchroniser; change counts when second and third agree.
    reg [2:0]  eot_sync_q;
    reg        eot_q;
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            eot_sync_q <= 3'h7;
            eot_q      <= 1'b0;
        end else if (ce_i) begin
            eot_sync_q <= {eot_sync_q[1:0], end_of_transfer_input_n_i};
            if (eot_sync_q[1] == eot_sync_q[2])
                eot_q <= ~eot_sync_q[2];
        end
    end

    wire eot_hit    = eot_q & mode_q[`MODE_EOT_EN];
    wire sg_mode    = mode_q[`MODE_SG];
    wire valid_mode = mode_q[`MODE_VALID_EN];
    wire wr_cs      = reg_wr_i && reg_addr_i == `ADR_CMD_STAT;
    wire start_wr   = wr_cs && reg_wdata_i[`CS_START];
    wire pause_wr   = wr_cs && !reg_wdata_i[`CS_START] && start_q;
    wire abort_wr   = wr_cs && reg_wdata_i[`CS_ABORT] && !reg_wdata_i[`CS_ENABLE];
    wire go         = start_wr && (wr_cs ? reg_wdata_i[`CS_ENABLE] : enable_q);
    wire busy       = state_q != `ST_IDLE && state_q != `ST_DONE;

    // Descriptor decode. Normal layout: pci, local, size, next. With valid mode the
    // size word comes first so the valid flag is checked before anything else.
    reg [31:0] d_pci;
    reg [31:0] d_loc;
    reg [31:0] d_size;
    reg [31:0] d_ptr;
    always @* begin
        if (valid_mode) begin
            d_size = w_q[0];
            d_pci  = w_q[1];
            d_loc  = w_q[2];
            d_ptr  = w_q[3];
        end else begin
            d_pci  = w_q[0];
            d_loc  = w_q[1];
            d_size = w_q[2];
            d_ptr  = w_q[3];
        end
    end

    wire d_valid = d_size[`SIZE_VALID];
    wire d_zero  = d_size[`SIZE_CNT_W-1:0] == {`SIZE_CNT_W{1'b0}};
    wire d_last  = d_ptr[`PTR_LAST];

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_q       <= `MODE_RESET;
            pci_addr_q   <= `ZERO32;
            loc_addr_q   <= `ZERO32;
            size_q       <= `ZERO32;
            ptr_q        <= `ZERO32;
            dac_q        <= `ZERO32;
            enable_q     <= 1'b0;
            start_q      <= 1'b0;
            done_q       <= 1'b0;
            int_q        <= 1'b0;
            halted_q     <= 1'b0;
            state_q      <= `ST_IDLE;
            wcnt_q       <= {`DW_CNT_W{1'b0}};
            desc_base_q  <= `ZERO32;
            desc_space_q <= 1'b0;
            count_q      <= {`SIZE_CNT_W{1'b0}};
            w_q[0]       <= `ZERO32;
            w_q[1]       <= `ZERO32;
            w_q[2]       <= `ZERO32;
            w_q[3]       <= `ZERO32;
        end else if (ce_i) begin
            if (reg_wr_i) begin
                case (reg_addr_i)
                    `ADR_MODE:     mode_q     <= reg_wdata_i & `MODE_WMASK;
                    `ADR_PCI_ADDR: pci_addr_q <= reg_wdata_i;
                    `ADR_LOC_ADDR: loc_addr_q <= reg_wdata_i;
                    `ADR_SIZE:     size_q     <= reg_wdata_i & `SIZE_WMASK;
                    `ADR_DESC_PTR: ptr_q      <= reg_wdata_i;
                    `ADR_DAC:      dac_q      <= reg_wdata_i;
                    `ADR_CMD_STAT: enable_q   <= reg_wdata_i[`CS_ENABLE];
                    default: ;
                endcase
            end
            if (wr_cs && reg_wdata_i[`CS_CLR_INT])
                int_q <= 1'b0;
            // The event wins over a clear in the same cycle, so it is placed after.
            case (state_q)
                `ST_IDLE, `ST_DONE: begin
                    if (go) begin
                        start_q  <= 1'b1;
                        done_q   <= 1'b0;
                        halted_q <= 1'b0;
                        if (sg_mode) begin
                            desc_base_q  <= ptr_q & `PTR_NEXT_MASK;
                            desc_space_q <= ptr_q[`PTR_IN_PCI];
                            wcnt_q       <= {`DW_CNT_W{1'b0}};
                            state_q      <= `ST_FETCH;
                        end else begin
                            count_q <= size_q[`SIZE_CNT_W-1:0];
                            state_q <= `ST_MOVE;
                        end
                    end
                end
                `ST_FETCH: begin
                    if (desc_ack_i) begin
                        w_q[wcnt_q] <= desc_data_i;
                        wcnt_q      <= wcnt_q + 2'h1;
                        if (wcnt_q == `DW_LAST)
                            state_q <= `ST_CHECK;
                    end
                end
                `ST_CHECK: begin
                    pci_addr_q <= d_pci;
                    loc_addr_q <= d_loc;
                    size_q     <= d_size & `SIZE_WMASK;
                    ptr_q      <= d_ptr;
                    // With DAC chain load the upper word rides in the descriptor's local-address
                    // slot; this channel keeps it in the DAC register.
                    if (mode_q[`MODE_DAC_LOAD])
                        dac_q <= d_loc;
                    count_q <= d_size[`SIZE_CNT_W-1:0];
                    if (valid_mode && !d_valid) begin
                        if (mode_q[`MODE_VALID_STOP]) begin
                            halted_q <= 1'b1;
                            start_q  <= 1'b0;
                            done_q   <= 1'b1;
                            state_q  <= `ST_DONE;
                        end else begin
                            wcnt_q  <= {`DW_CNT_W{1'b0}};
                            state_q <= `ST_FETCH;
                        end
                    end else if (valid_mode && d_zero && !d_last) begin
                        state_q <= `ST_NEXT;
                    end else begin
                        state_q <= `ST_MOVE;
                    end
                end
                `ST_MOVE: begin
                    if (eot_hit) begin
                        if (sg_mode && mode_q[`MODE_END_LINK] && !ptr_q[`PTR_LAST])
                            state_q <= `ST_NEXT;
                        else begin
                            start_q <= 1'b0;
                            done_q  <= 1'b1;
                            state_q <= `ST_DONE;
                        end
                    end else if (count_q == {`SIZE_CNT_W{1'b0}}) begin
                        if (ptr_q[`PTR_TC_INT] || !sg_mode)
                            int_q <= ptr_q[`PTR_TC_INT];
                        if (sg_mode && !ptr_q[`PTR_LAST])
                            state_q <= `ST_NEXT;
                        else begin
                            start_q <= 1'b0;
                            done_q  <= 1'b1;
                            state_q <= `ST_DONE;
                        end
                    end else if (move_beat_i) begin
                        count_q <= (count_q > `BYTES_PER_BEAT) ?
                                   count_q - `BYTES_PER_BEAT : {`SIZE_CNT_W{1'b0}};
                        pci_addr_q <= pci_addr_q + 32'h0000_0004;
                        loc_addr_q <= loc_addr_q + 32'h0000_0004;
                    end
                end
                `ST_NEXT: begin
                    desc_base_q  <= ptr_q & `PTR_NEXT_MASK;
                    desc_space_q <= ptr_q[`PTR_IN_PCI];
                    wcnt_q       <= {`DW_CNT_W{1'b0}};
                    state_q      <= `ST_FETCH;
                end
                default: state_q <= `ST_IDLE;
            endcase
            // Pause or abort overrides the walker; done reports it.
            if (busy && (pause_wr || abort_wr || (wr_cs && !reg_wdata_i[`CS_ENABLE]))) begin
                start_q <= 1'b0;
                done_q  <= 1'b1;
                state_q <= `ST_DONE;
            end
        end
    end

    // Read mux and outputs, all registered.
    reg [31:0] rd_d;
    always @* begin
        case (reg_addr_i)
            `ADR_MODE:     rd_d = mode_q;
            `ADR_PCI_ADDR: rd_d = pci_addr_q;
            `ADR_LOC_ADDR: rd_d = loc_addr_q;
            `ADR_SIZE:     rd_d = size_q;
            `ADR_DESC_PTR: rd_d = ptr_q;
            `ADR_DAC:      rd_d = dac_q;
            `ADR_CMD_STAT: rd_d = {27'h000_0000, done_q, int_q, 1'b0, start_q, enable_q};
            `ADR_STATUS:   rd_d = {20'h0_0000, halted_q, state_q, 8'h00};
            default:       rd_d = `ZERO32;
        endcase
    end

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rdata_o             <= `ZERO32;
            desc_req_o              <= 1'b0;
            desc_in_pci_o           <= 1'b0;
            desc_addr_o             <= `ZERO32;
            move_active_o           <= 1'b0;
            move_loc_to_pci_o       <= 1'b0;
            move_pci_addr_o         <= `ZERO32;
            move_dac_o              <= `ZERO32;
            move_loc_addr_o         <= `ZERO32;
            pci_inta_n_o            <= 1'b1;
            local_interrupt_out_n_o <= 1'b1;
        end else if (ce_i) begin
            reg_rdata_o       <= reg_rd_i ? rd_d : `ZERO32;
            desc_req_o        <= state_q == `ST_FETCH && !(desc_ack_i && wcnt_q == `DW_LAST);
            desc_in_pci_o     <= desc_space_q;
            desc_addr_o       <= desc_base_q | {28'h000_0000, (desc_ack_i ? wcnt_q + 2'h1 : wcnt_q), 2'h0};
            move_active_o     <= state_q == `ST_MOVE && count_q != {`SIZE_CNT_W{1'b0}} && !eot_hit;
            move_loc_to_pci_o <= ptr_q[`PTR_LOC_TO_PCI];
            move_pci_addr_o   <= pci_addr_q;
            move_dac_o        <= dac_q;
            move_loc_addr_o   <= loc_addr_q;
            pci_inta_n_o            <= ~(int_q & mode_q[`MODE_INT_PCI]);
            local_interrupt_out_n_o <= ~(int_q & ~mode_q[`MODE_INT_PCI]);
        end
    end

endmodule // dma_sg_channel

// ==== src/dma_sg_defs.vh ====
// Register offsets, field positions, reset values and state codes of the descriptor channel.
`ifndef DMA_SG_DEFS_VH
`define DMA_SG_DEFS_VH

`define ADR_MODE        4'h0
`define ADR_PCI_ADDR    4'h1
`define ADR_LOC_ADDR    4'h2
`define ADR_SIZE        4'h3
`define ADR_DESC_PTR    4'h4
`define ADR_DAC         4'h5
`define ADR_CMD_STAT    4'h6
`define ADR_STATUS      4'h7

`define MODE_SG         9
`define MODE_EOT_EN     14
`define MODE_INT_PCI    17
`define MODE_DAC_LOAD   18
`define MODE_END_LINK   19
`define MODE_VALID_EN   20
`define MODE_VALID_STOP 21
`define MODE_RESET      32'h0000_0003
`define MODE_WMASK      32'h003F_FFFF

`define SIZE_CNT_W      23
`define SIZE_VALID      31
`define SIZE_WMASK      32'h807F_FFFF

`define PTR_IN_PCI      0
`define PTR_LAST        1
`define PTR_TC_INT      2
`define PTR_LOC_TO_PCI  3
`define PTR_NEXT_MASK   32'hFFFF_FFF0

`define CS_ENABLE       0
`define CS_START        1
`define CS_ABORT        2
`define CS_CLR_INT      3
`define CS_DONE         4

`define ST_IDLE         3'h0
`define ST_FETCH        3'h1
`define ST_CHECK        3'h2
`define ST_MOVE         3'h3
`define ST_NEXT         3'h4
`define ST_DONE         3'h5

// Word counter in a descriptor fetch.
`define DW_CNT_W        2
`define DW_LAST         2'h3
`define ZERO32          32'h0000_0000
`define BYTES_PER_BEAT  23'h00_0004

`endif

// ==== tb/dma_sg_channel_assertions.sv ====
// Port-level checks of the descriptor channel.
`timescale 1ns/1ns
`include "dma_sg_defs.vh"
module dma_sg_checker (
    // Clock and reset
    input wire        clk_i,
    input wire        rst_n_i,
    // Register port
    input wire [3:0]  reg_addr_i,
    input wire [31:0] reg_wdata_i,
    input wire        reg_wr_i,
    input wire        reg_rd_i,
    input wire [31:0] reg_rdata_o,
    // Descriptor fetch and mover
    input wire        desc_req_o,
    input wire [31:0] desc_addr_o,
    input wire        desc_ack_i,
    input wire [31:0] desc_data_i,
    input wire        move_active_o,
    input wire        move_loc_to_pci_o,
    input wire [31:0] move_pci_addr_o,
    input wire [31:0] move_dac_o,
    input wire [31:0] move_loc_addr_o,
    // Interrupt pins
    input wire        pci_inta_n_o,
    input wire        local_interrupt_out_n_o
);
    reg  [31:0] mode_q;
    reg  [31:0] dac_q;
    reg  [31:0] w_q [0:3];
    reg  [1:0]  n_q;
    wire        vm = mode_q[`MODE_VALID_EN];
    wire [31:0] pw = vm ? w_q[1] : w_q[0];
    wire [31:0] lw = vm ? w_q[2] : w_q[1];
    wire [31:0] sw = vm ? w_q[0] : w_q[2];
    // Shadows of the mode and upper-address registers and the last fetched descriptor.
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_q <= `MODE_RESET;
            dac_q  <= `ZERO32;
            n_q    <= 2'h0;
        end else begin
            if (reg_wr_i && reg_addr_i == `ADR_MODE) mode_q <= reg_wdata_i & `MODE_WMASK;
            if (reg_wr_i && reg_addr_i == `ADR_DAC) dac_q <= reg_wdata_i;
            if (desc_ack_i) begin
                w_q[n_q] <= desc_data_i;
                n_q      <= n_q + 2'h1;
            end
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    a_size_rsvd_zero: assert property (reg_rd_i && reg_addr_i == `ADR_SIZE
        |=> reg_rdata_o[30:23] == 8'h00) else $error("size reserved bits not zero");
    a_fetch_word_align: assert property (desc_req_o
        |-> desc_addr_o[3:0] == {n_q, 2'h0}) else $error("descriptor word address wrong");
    a_pci_int_route: assert property ($fell(pci_inta_n_o)
        |-> mode_q[`MODE_INT_PCI]) else $error("interrupt on wrong pin");
    a_loc_int_route: assert property ($fell(local_interrupt_out_n_o)
        |-> !mode_q[`MODE_INT_PCI]) else $error("interrupt on wrong pin");
    a_move_start_addr: assert property ($rose(move_active_o)
        |-> move_pci_addr_o == pw && move_loc_addr_o == lw) else $error("start address wrong");
    a_move_direction: assert property ($rose(move_active_o)
        |-> move_loc_to_pci_o == w_q[3][3]) else $error("direction wrong");
    a_skip_zero_count: assert property ($rose(move_active_o)
        |-> sw[22:0] != 23'h00_0000) else $error("zero count moved");
    a_valid_gate: assert property ($rose(move_active_o) && vm
        |-> sw[`SIZE_VALID]) else $error("invalid descriptor moved");
    a_dac_held: assert property ($rose(move_active_o) && !mode_q[`MODE_DAC_LOAD]
        |-> move_dac_o == dac_q) else $error("upper address not from register");
endmodule // dma_sg_checker

bind dma_sg_channel dma_sg_checker chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .desc_req_o(desc_req_o),
    .desc_addr_o(desc_addr_o), .desc_ack_i(desc_ack_i), .desc_data_i(desc_data_i),
    .move_active_o(move_active_o), .move_loc_to_pci_o(move_loc_to_pci_o),
    .move_pci_addr_o(move_pci_addr_o), .move_dac_o(move_dac_o),
    .move_loc_addr_o(move_loc_addr_o), .pci_inta_n_o(pci_inta_n_o),
    .local_interrupt_out_n_o(local_interrupt_out_n_o));

// ==== tb/dma_sg_far_end.sv ====
// Descriptor memory and data mover on the far side of the channel.
`timescale 1ns/1ns
module dma_sg_far_end (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_n_i,
    // Answer delay in cycles
    input  wire [3:0]  delay_i,
    // Descriptor fetch
    input  wire        desc_req_i,
    input  wire [31:0] desc_addr_i,
    output reg         desc_ack_o,
    output reg  [31:0] desc_data_o,
    // Mover
    input  wire        move_active_i,
    output reg         move_beat_o
);
    reg [31:0] mem [0:63];
    reg [3:0]  wait_q;
    // Between answers the data word toggles, so a late sample never matches by luck.
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            desc_ack_o  <= 1'b0;
            desc_data_o <= 32'h5A5A_A5A5;
            wait_q      <= 4'h0;
            move_beat_o <= 1'b0;
        end else begin
            desc_ack_o  <= 1'b0;
            desc_data_o <= ~desc_data_o;
            move_beat_o <= move_active_i && !move_beat_o;
            if (desc_req_i && !desc_ack_o) begin
                wait_q <= (wait_q == delay_i) ? 4'h0 : wait_q + 4'h1;
                if (wait_q == delay_i) begin
                    desc_ack_o  <= 1'b1;
                    desc_data_o <= mem[desc_addr_i[7:2]];
                end
            end
        end
    end
endmodule // dma_sg_far_end

// ==== tb/test_dma_scatter_gather_descriptor.sv ====
// Register-level tests of the descriptor channel against a behavioural far end.
`timescale 1ns/1ns
`include "dma_sg_defs.vh"
module test_dma_scatter_gather_descriptor;
    reg         clk_i = 1'b0;
    reg         rst_n_i = 1'b0;
    reg  [3:0]  reg_addr_i = 4'h0;
    reg  [31:0] reg_wdata_i = 32'h0000_0000;
    reg         reg_wr_i = 1'b0;
    reg         reg_rd_i = 1'b0;
    reg  [3:0]  delay = 4'h0;
    reg         eot_n = 1'b1;
    wire [31:0] reg_rdata_o, desc_addr_o, desc_data_i, move_pci_addr_o, move_dac_o, move_loc_addr_o;
    wire        desc_req_o, desc_in_pci_o, desc_ack_i, move_active_o, move_loc_to_pci_o;
    wire        move_beat_i, pci_inta_n_o, local_interrupt_out_n_o;
    integer     n_mismatch = 0, checks = 0, beats = 0, i, r;
    reg  [31:0] d;
    reg  [32:0] mv_q [$];
    reg         was = 1'b0, space = 1'b0;
    initial forever #2 clk_i = ~clk_i;
    dma_sg_channel dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .desc_req_o(desc_req_o), .desc_in_pci_o(desc_in_pci_o),
        .desc_addr_o(desc_addr_o), .desc_ack_i(desc_ack_i), .desc_data_i(desc_data_i),
        .move_active_o(move_active_o), .move_loc_to_pci_o(move_loc_to_pci_o),
        .move_pci_addr_o(move_pci_addr_o), .move_dac_o(move_dac_o),
        .move_loc_addr_o(move_loc_addr_o), .move_beat_i(move_beat_i),
        .end_of_transfer_input_n_i(eot_n), .pci_inta_n_o(pci_inta_n_o),
        .local_interrupt_out_n_o(local_interrupt_out_n_o));
    dma_sg_far_end far (.clk_i(clk_i), .rst_n_i(rst_n_i), .delay_i(delay),
        .desc_req_i(desc_req_o), .desc_addr_i(desc_addr_o), .desc_ack_o(desc_ack_i),
        .desc_data_o(desc_data_i), .move_active_i(move_active_o), .move_beat_o(move_beat_i));
    // Each link start is logged with its direction, together with beats and fetch space.
    always @(posedge clk_i) begin
        if (move_active_o && move_beat_i) beats = beats + 1;
        if (desc_req_o) space = desc_in_pci_o;
        if (move_active_o && !was) mv_q.push_back({move_loc_to_pci_o, move_pci_addr_o});
        was = move_active_o;
    end
    task stop_test;
        begin
            $display("checks %0d mismatches %0d", checks, n_mismatch);
            if (n_mismatch == 0 && checks > 0) $display("No errors found");
            else $display("Errors were found");
            $finish;
        end
    endtask
    task chk(input string name, input [32:0] exp, input [32:0] got);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("mismatch %s expected %h seen %h", name, exp, got);
            end
        end
    endtask
    task wr(input [3:0] a, input [31:0] v);
        begin
            @(posedge clk_i);
            reg_addr_i  <= a;
            reg_wdata_i <= v;
            reg_wr_i    <= 1'b1;
            @(posedge clk_i);
            reg_wr_i    <= 1'b0;
        end
    endtask
    task rd(input [3:0] a, output [31:0] v);
        begin
            @(posedge clk_i);
            reg_addr_i <= a;
            reg_rd_i   <= 1'b1;
            @(posedge clk_i);
            reg_rd_i   <= 1'b0;
            #1 v = reg_rdata_o;
        end
    endtask
    task wait_set(input [3:0] a, input integer b, input integer n);
        integer k;
        begin
            for (k = 0; k < n; k = k + 1) begin
                rd(a, d);
                if (d[b] === 1'b1) k = n + 1;
            end
            if (k == n) begin
                chk("wait bit", 1, 0);
                stop_test;
            end
        end
    endtask
    task run(input [31:0] p);
        begin
            beats = 0;
            mv_q.delete();
            wr(`ADR_DESC_PTR, p);
            wr(`ADR_CMD_STAT, 32'h0000_0003);
        end
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        for (i = 0; i < 5; i = i + 1) begin
            rd(i[3:0], d);
            chk("reset value", (i == 0) ? `MODE_RESET : 0, d);
        end
        rd(4'h8, d);
        chk("unmapped", 0, d);
        wr(`ADR_SIZE, 32'hFFFF_FFFF);
        rd(`ADR_SIZE, d);
        chk("size mask", 32'h807F_FFFF, d);
        wr(`ADR_DAC, 32'h0000_0055);
        wr(`ADR_MODE, 32'h0000_0203);
        wr(`ADR_CMD_STAT, 32'h0000_0002);
        repeat (20) @(posedge clk_i);
        rd(`ADR_STATUS, d);
        chk("start without enable", `ST_IDLE, d[10:8]);
        far.mem[16] = 32'h0000_1000; far.mem[17] = 32'h0000_2000;
        far.mem[18] = 32'h0000_0008; far.mem[19] = 32'h0000_0088;
        far.mem[32] = 32'h0000_3000; far.mem[33] = 32'h0000_4000;
        far.mem[34] = 32'h0000_000C; far.mem[35] = 32'h0000_0006;
        for (r = 0; r < 2; r = r + 1) begin
            delay = r * 3;
            far.mem[19] = 32'h0000_0088 | r;
            wr(`ADR_MODE, r ? 32'h0002_0203 : 32'h0000_0203);
            run(32'h0000_0040 | r);
            wait_set(`ADR_CMD_STAT, `CS_DONE, 400);
            chk("beats", 5, beats);
            chk("first link", 33'h1_0000_1000, mv_q[0]);
            chk("second link", 33'h0_0000_3000, mv_q[1]);
            chk("fetch space", r, space);
            chk("interrupts", {!r[0], r[0]}, {pci_inta_n_o, local_interrupt_out_n_o});
            wr(`ADR_CMD_STAT, 32'h0000_0008);
            rd(`ADR_STATUS, d);
            chk("interrupts cleared", 2'h3, {pci_inta_n_o, local_interrupt_out_n_o});
        end
        far.mem[48] = 32'h0000_0000; far.mem[49] = 32'h0000_5000;
        far.mem[50] = 32'h0000_6000; far.mem[51] = 32'h0000_00D0;
        far.mem[52] = 32'h8000_0004; far.mem[53] = 32'h0000_7000;
        far.mem[54] = 32'h0000_8000; far.mem[55] = 32'h0000_0002;
        wr(`ADR_MODE, 32'h0030_0203);
        run(32'h0000_00C0);
        wait_set(`ADR_STATUS, 11, 200);
        chk("halted beats", 0, beats);
        far.mem[48] = 32'h8000_0000;
        run(32'h0000_00C0);
        wait_set(`ADR_CMD_STAT, `CS_DONE, 400);
        chk("skipped link", 33'h0_0000_7000, mv_q[0]);
        chk("skip beats", 1, beats);
        far.mem[56] = 32'h0000_9000; far.mem[57] = 32'h0000_A000;
        far.mem[58] = 32'h0000_0400; far.mem[59] = 32'h0000_0002;
        wr(`ADR_MODE, 32'h0000_0203);
        run(32'h0000_00E0);
        repeat (30) @(posedge clk_i);
        wr(`ADR_CMD_STAT, 32'h0000_0001);
        wait_set(`ADR_CMD_STAT, `CS_DONE, 20);
        // End-of-transfer mid link: end-link set walks on through the chain, clear stops it.
        far.mem[59] = 32'h0000_0040;
        for (r = 0; r < 2; r = r + 1) begin
            wr(`ADR_MODE, r ? 32'h0008_4203 : 32'h0000_4203);
            run(32'h0000_00E0);
            repeat (30) @(posedge clk_i);
            eot_n <= 1'b0;
            repeat (6) @(posedge clk_i);
            eot_n <= 1'b1;
            wait_set(`ADR_CMD_STAT, `CS_DONE, 100);
            chk("links after end", r ? 3 : 1, mv_q.size());
        end
        stop_test;
    end
endmodule // test_dma_scatter_gather_descriptor
